// [hw/vid_reference_update.v]
// Functional notes
// R1 - Fine mode: six-bit code, 12.5 mV per step
// R2 - Fine mode: sample code six times per cycle
// R3 - Fine mode: accept after three equal samples
// R4 - Fine mode: apply validated code directly, no slew
// R5 - Processor changes fine code one step only
// R6 - Coarse mode accepts multi-step code jumps
// R7 - Coarse: wait half cycle, slew 12.5 mV/cycle
// R8 - Coarse recognition may lag one full cycle
// R9 - No-load codes: shutdown after two cycles
// R10 - Mode fixed at start; phase clock times all
`timescale 1ns/1ps
`include "vid_reference_update_map.vh"

module vid_reference_update #(
	parameter PHASE_DIV = `PHASE_DIV
) (
	input wire mclk,
	input wire nrst,
	input wire fine_mode,
	input wire code_bit_msb,
	input wire code_bit_3,
	input wire code_bit_2,
	input wire code_bit_1,
	input wire code_bit_lsb,
	input wire code_half_step_bit,
	output reg [`REF_W-1:0] decoded_reference_level,
	output reg shutdown,
	output reg restart_soft_start,
	output wire phase_clk
);
	// ------------------------------------------------------------------
	// Reset release and mode capture
	// ------------------------------------------------------------------
	reg rst_a_q;
	reg rst_b_q;
	wire rst_n;
	reg mode_cap_q;
	reg fine_q;

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_a_q <= 1'b0;
			rst_b_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_b_q <= rst_a_q;
		end
	end
	assign rst_n = rst_b_q;

	// The mode pin is a strap: later changes are ignored on purpose.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_cap_q <= 1'b0;
			fine_q <= 1'b0;
		end else if (!mode_cap_q) begin
			mode_cap_q <= 1'b1;
			fine_q <= fine_mode; // R10
		end
	end

	// ------------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------------
	wire phase_tick;
	wire half_tick;
	wire sample_tick;

	phase_timebase #(
		.PHASE_DIV(PHASE_DIV),
		.SAMPLES(`SAMPLES_PER_PHASE)
	) u_timebase (
		.mclk(mclk),
		.rst_n(rst_n),
		.phase_tick(phase_tick),
		.half_tick(half_tick),
		.sample_tick(sample_tick)
	);
	// High while held in reset too, since the counter rests at zero.
	assign phase_clk = phase_tick;

	// ------------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------------
	function [`REF_W-1:0] ref_of;
		input fine;
		input [5:0] code;
		begin
			if (fine)
				ref_of = `FINE_BASE - {2'h0, code}; // R1
			else
				ref_of = `COARSE_BASE - {2'h0, code[5:1], 1'b0};
		end
	endfunction

	function is_noload;
		input fine;
		input [5:0] code;
		begin
			if (fine)
				is_noload = (code == `NOLOAD_FINE_A) ||
					(code == `NOLOAD_FINE_B); // R9
			else
				is_noload = (code[5:1] == `NOLOAD_COARSE); // R9
		end
	endfunction

	// One step per call keeps the coarse ramp at one 12.5 mV step, half a coarse code, per cycle.
	function [`REF_W-1:0] step_toward;
		input [`REF_W-1:0] cur;
		input [`REF_W-1:0] tgt;
		begin
			if (cur < tgt)
				step_toward = cur + `REF_STEP; // R7
			else if (cur > tgt)
				step_toward = cur - `REF_STEP; // R7
			else
				step_toward = cur;
		end
	endfunction

	wire [5:0] code_in;
	assign code_in = {code_bit_msb, code_bit_3, code_bit_2, code_bit_1,
		code_bit_lsb, code_half_step_bit};

	// ------------------------------------------------------------------
	// Code acceptance and reference update
	// ------------------------------------------------------------------
	reg [5:0] cand_q;
	reg [1:0] cnt_q;
	reg [5:0] acc_q;
	reg new_q;
	reg wait_q;
	reg [1:0] nl_cnt_q;
	wire [5:0] coarse_in;
	wire [`REF_W-1:0] target;
	wire acc_noload;

	// In coarse mode the half-step pin carries no weight.
	assign coarse_in = {code_in[5:1], 1'b0};
	assign target = ref_of(fine_q, acc_q);
	assign acc_noload = is_noload(fine_q, acc_q);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cand_q <= `NOLOAD_FINE_A;
			cnt_q <= 2'h0;
			acc_q <= `NOLOAD_FINE_A;
			new_q <= 1'b0;
			wait_q <= 1'b0;
			nl_cnt_q <= 2'h0;
			decoded_reference_level <= `REF_RESET;
			shutdown <= 1'b1;
			restart_soft_start <= 1'b0;
		end else begin
			new_q <= 1'b0;
			restart_soft_start <= 1'b0;
			if (!mode_cap_q) begin
				cnt_q <= 2'h0;
			end else if (fine_q) begin
				if (sample_tick) begin
					if (code_in == acc_q) begin
						cnt_q <= 2'h0;
					end else if (code_in != cand_q || cnt_q == 2'h0) begin
						cand_q <= code_in;
						cnt_q <= 2'h1;
					end else if (cnt_q + 2'h1 == `VALID_SAMPLES) begin
						acc_q <= code_in; // R3
						new_q <= 1'b1;
						cnt_q <= 2'h0;
					end else begin
						cnt_q <= cnt_q + 2'h1; // R3
					end
				end
			end else if (phase_tick && coarse_in != acc_q) begin
				// Once per cycle, so a change may wait a full cycle.
				acc_q <= coarse_in; // R8
				new_q <= 1'b1; // R6
			end

			// Reference tracks the accepted code while running.
			if (!shutdown && !acc_noload) begin
				if (fine_q) begin
					if (new_q)
						decoded_reference_level <= target; // R4
				end else begin
					if (new_q)
						wait_q <= 1'b1;
					if (half_tick && (wait_q || new_q) &&
						decoded_reference_level != target) begin
						decoded_reference_level <= step_toward(
							decoded_reference_level, target); // R7
					end else if (half_tick && !new_q &&
						decoded_reference_level == target) begin
						wait_q <= 1'b0;
					end
				end
			end

			// No-load handling and restart.
			if (acc_noload) begin
				wait_q <= 1'b0;
				if (!shutdown && phase_tick) begin
					if (nl_cnt_q + 2'h1 == `SHUTDOWN_DELAY)
						shutdown <= 1'b1; // R9
					else
						nl_cnt_q <= nl_cnt_q + 2'h1;
				end
			end else begin
				nl_cnt_q <= 2'h0;
				if (shutdown && mode_cap_q) begin
					// Soft-start ramps from here, so load the level directly.
					shutdown <= 1'b0;
					restart_soft_start <= 1'b1; // R9
					decoded_reference_level <= target;
				end
			end
		end
	end
endmodule // vid_reference_update

// [hw/vid_reference_update_map.vh]
`ifndef VID_REFERENCE_UPDATE_MAP_VH
`define VID_REFERENCE_UPDATE_MAP_VH

// ----------------------------------------------------------------------
// Reference encoding, in 12.5 mV steps
// ----------------------------------------------------------------------
`define REF_W 8
`define FINE_BASE 8'h95
`define COARSE_BASE 8'h94
`define REF_RESET 8'h00
`define REF_STEP 8'h01

// ----------------------------------------------------------------------
// No-load codes
// ----------------------------------------------------------------------
`define NOLOAD_FINE_A 6'h3f
`define NOLOAD_FINE_B 6'h3e
`define NOLOAD_COARSE 5'h1f

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define PHASE_DIV 120
`define SAMPLES_PER_PHASE 6
`define VALID_SAMPLES 2'h3
`define SHUTDOWN_DELAY 2'h2

`endif

// [hw/phase_timebase.v]
`timescale 1ns/1ps
`include "vid_reference_update_map.vh"

module phase_timebase #(
	parameter PHASE_DIV = `PHASE_DIV,
	parameter SAMPLES = `SAMPLES_PER_PHASE
) (
	input wire mclk,
	input wire rst_n,
	output wire phase_tick,
	output wire half_tick,
	output wire sample_tick
);
	localparam SUB_DIV = PHASE_DIV / SAMPLES;
	localparam [31:0] LAST_W = PHASE_DIV - 1;
	localparam [31:0] HALF_W = PHASE_DIV / 2;
	localparam [31:0] SUB_LAST_W = SUB_DIV - 1;
	localparam [15:0] LAST = LAST_W[15:0];
	localparam [15:0] HALF = HALF_W[15:0];
	localparam [15:0] SUB_LAST = SUB_LAST_W[15:0];

	reg [15:0] cyc_q;
	reg [15:0] sub_q;

	// ------------------------------------------------------------------
	// Switching cycle and sampling counters
	// ------------------------------------------------------------------
	// Both counters restart together so six samples land in every cycle.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= 16'h0000;
			sub_q <= 16'h0000;
		end else begin
			if (cyc_q == LAST) begin
				cyc_q <= 16'h0000;
				sub_q <= 16'h0000;
			end else begin
				cyc_q <= cyc_q + 16'h0001;
				sub_q <= (sub_q == SUB_LAST) ? 16'h0000 : sub_q + 16'h0001;
			end
		end
	end

	assign phase_tick = (cyc_q == 16'h0000);
	assign half_tick = (cyc_q == HALF);
	assign sample_tick = (sub_q == 16'h0000); // R2
endmodule // phase_timebase

// [bench/vid_ref_properties.sv]
`timescale 1ns/1ps
module vid_ref_props #(parameter PHASE_DIV = 120) (
	input wire mclk,
	input wire nrst,
	input wire fine_mode,
	input wire code_bit_msb,
	input wire code_bit_3,
	input wire code_bit_2,
	input wire code_bit_1,
	input wire code_bit_lsb,
	input wire code_half_step_bit,
	input wire [7:0] decoded_reference_level,
	input wire shutdown,
	input wire restart_soft_start,
	input wire phase_clk
);
	localparam int P = PHASE_DIV;
	localparam int D = 2 * (P / 6) + 2;
	localparam int H = P / 2 + 1;
	reg [2:0] live_q;
	wire [5:0] c = {code_bit_msb, code_bit_3, code_bit_2, code_bit_1,
		code_bit_lsb, code_half_step_bit};
	wire [7:0] r = decoded_reference_level;
	wire nr = !restart_soft_start;
	wire live;
	// The design runs two edges after nrst and takes its mode one later.
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			live_q <= 3'h0;
		else
			live_q <= {live_q[1:0], 1'b1};
	end
	assign live = live_q[2];
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!live);
	sequence s_quiet;
		$stable(r)[*8];
	endsequence
	a_phase_period: assert property (
		phase_clk |-> ##[P:P] phase_clk) else $error("phase spacing");
	a_phase_single: assert property (
		phase_clk |=> !phase_clk) else $error("phase pulse too long");
	a_fine_decode: assert property (
		fine_mode && nr && !shutdown && $changed(r) |->
		r == 8'h95 - $past(c, 2)) else $error("fine ref value");
	a_fine_three: assert property (
		fine_mode && nr && !shutdown && $changed(r) |->
		$past(c, D) == $past(c, 2)) else $error("fine ref early");
	a_coarse_half: assert property (
		!fine_mode && nr && $changed(r) |-> $past(phase_clk, H))
		else $error("coarse step off half cycle");
	a_coarse_step: assert property (
		!fine_mode && nr && $changed(r) |->
		(r - $past(r) == 8'h01) || ($past(r) - r == 8'h01))
		else $error("coarse step size");
	a_coarse_gap: assert property (
		!fine_mode && nr && $changed(r) |=> s_quiet)
		else $error("coarse step rate");
	a_shut_freeze: assert property (
		shutdown ##1 shutdown |-> $stable(r)) else $error("ref moved");
	a_shut_cause: assert property (
		$rose(shutdown) |-> c[5:1] == 5'h1f) else $error("bad shutdown");
	a_restart_once: assert property (
		restart_soft_start |-> $fell(shutdown) ##1 !restart_soft_start)
		else $error("restart pulse");
endmodule // vid_ref_props

bind vid_reference_update vid_ref_props #(.PHASE_DIV(PHASE_DIV)) u_props (
	.mclk(mclk), .nrst(nrst), .fine_mode(fine_mode),
	.code_bit_msb(code_bit_msb), .code_bit_3(code_bit_3),
	.code_bit_2(code_bit_2), .code_bit_1(code_bit_1),
	.code_bit_lsb(code_bit_lsb), .code_half_step_bit(code_half_step_bit),
	.decoded_reference_level(decoded_reference_level),
	.shutdown(shutdown), .restart_soft_start(restart_soft_start),
	.phase_clk(phase_clk));

// [bench/proc_code_drv.sv]
`timescale 1ns/1ps
module proc_code_drv (
	input wire mclk,
	input wire [5:0] code_req,
	output reg [5:0] code_pins
);
	initial code_pins = 6'h3f;
	// All bits move on one edge, so no mixed code is ever seen.
	always @(posedge mclk) begin
		code_pins <= code_req;
	end
endmodule // proc_code_drv

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	reg mclk = 1'b0;
	reg nrst = 1'b0;
	reg fine_mode = 1'b1;
	reg [5:0] code_req = 6'h3f;
	wire [5:0] cp;
	wire [7:0] rl;
	wire sd;
	wire rs;
	integer err_total = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer n_rs = 0;
	integer c;
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	proc_code_drv u_proc_code_drv (.mclk(mclk), .code_req(code_req),
		.code_pins(cp));
	vid_reference_update #(.PHASE_DIV(12)) u_vid_reference_update (
		.mclk(mclk), .nrst(nrst), .fine_mode(fine_mode),
		.code_bit_msb(cp[5]), .code_bit_3(cp[4]), .code_bit_2(cp[3]),
		.code_bit_1(cp[2]), .code_bit_lsb(cp[1]),
		.code_half_step_bit(cp[0]), .decoded_reference_level(rl),
		.shutdown(sd), .restart_soft_start(rs), .phase_clk());
	task final_report;
		begin
			if (err_total == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (rs === 1'b1)
			n_rs <= n_rs + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			final_report;
		end
	end
	task chk(input [7:0] got, input [7:0] exp);
		begin
			#1;
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task go(input [5:0] v, input integer n);
		begin
			code_req <= v;
			repeat (n) @(posedge mclk);
		end
	endtask
	task do_reset(input m);
		begin
			nrst <= 1'b0;
			fine_mode <= m;
			repeat (8) @(posedge mclk);
			nrst <= 1'b1;
		end
	endtask
	task t_fine;
		begin
			do_reset(1'b1);
			go(6'h28, 60);
			chk(rl, 8'h6d);
			chk(n_rs[7:0], 8'h01);
			for (c = 39; c >= 21; c = c - 1) begin
				go(c[5:0], 30);
				chk(rl, 8'h95 - c[7:0]);
			end
			// Four cycles hold two samples only, so it must be ignored.
			go(6'h14, 4);
			go(6'h15, 6);
			chk(rl, 8'h80);
			go(6'h3e, 40);
			chk({7'h00, sd}, 8'h01);
			chk(rl, 8'h80);
			go(6'h20, 40);
			chk({7'h00, sd}, 8'h00);
			chk(rl, 8'h75);
			chk(n_rs[7:0], 8'h02);
		end
	endtask
	task t_coarse;
		begin
			do_reset(1'b0);
			go(6'h21, 60);
			chk(rl, 8'h74);
			chk(n_rs[7:0], 8'h03);
			go(6'h10, 150);
			chk({7'h00, rl > 8'h74 && rl < 8'h84}, 8'h01);
			go(6'h10, 86);
			chk(rl, 8'h84);
			go(6'h3e, 40);
			chk({7'h00, sd}, 8'h01);
		end
	endtask
	initial begin
		@(posedge mclk);
		t_fine;
		t_coarse;
		final_report;
	end
endmodule // tb_top
